// *** rtl/ntw_pkg.sv ***
// Constants, field layouts and helpers for the cross-domain endpoint window decoder
// Contract
// - Up to eight endpoints; only the four endpoint-bearing port modes carry one.
// - Each endpoint has six window base registers, zero through five.
// - Windows decode memory space only; I/O requests are never claimed.
// - All windows translate directly; only two and four may select lookup translation.
// - Even plus odd register form a 64-bit prefetchable window; odd gives upper base.
// - In a merged pair the odd setup register stays read-write but is ignored.
// - Register zero, alone or paired, may map the 4 KB configuration space.
// - Each window has a setup register: enable, mode, size, translation method.
// - Window size shows as read-only zero base bits, so it is a power of two.
// - Limit register low 10 bits read as ones, giving 1 KB limit granularity.
// - Effective aperture is settable in 1 KB steps up to the requested size.
// - A limit below the base disables the window completely; here requests inside its aperture still complete as unsupported.
// - A limit inside the aperture ends the effective aperture, inclusive.
// - A limit beyond base plus size is ignored; full aperture applies.
// - Limit registers reset to the highest address, so they have no effect.
// - With configuration mapping, register zero's limit register is ignored.
// - In a 64-bit pair the odd limit register gives the upper limit bits.
// - A request outside a window's aperture is not handled by that window.
// - Inside the aperture but beyond the effective aperture means unsupported request.
// - Configuration mapping forces the window size to 4 KB.
package ntw_pkg;
  localparam int NUM_EP = 8;
  localparam int NUM_BAR = 6;
  localparam logic [7:0] OFS_BAR = 8'h00;
  localparam logic [7:0] OFS_SETUP = 8'h20;
  localparam logic [7:0] OFS_LIMIT = 8'h40;
  localparam logic [7:0] OFS_STATUS = 8'h60;
  localparam int SU_EN_BIT = 0;
  localparam int SU_MODE64_BIT = 1;
  localparam int SU_CFGMAP_BIT = 2;
  localparam int SU_SIZE_LSB = 4;
  localparam int SU_LUT_BIT = 12;
  localparam logic [31:0] SU_RW_MASK = 32'h0000_13f7;
  localparam logic [31:0] SU_LUT_MASK = 32'h0000_1000;
  localparam logic [31:0] SETUP_RST = 32'h0000_00c0;
  localparam logic [31:0] BAR_RST = 32'h0000_0000;
  localparam logic [31:0] LIMIT_RST = 32'hffff_ffff;
  localparam logic [9:0] LIMIT_LOW_ONES = 10'h3ff;
  localparam logic [63:0] LIMIT_MAX64 = 64'hffff_ffff_ffff_ffff;
  localparam logic [5:0] SIZE_MIN = 6'h0a;
  localparam logic [5:0] SIZE_MAX32 = 6'h1f;
  localparam logic [5:0] CFG_SIZE = 6'h0c;
  localparam logic [3:0] BAR_TYPE32 = 4'h0;
  localparam logic [3:0] BAR_TYPE64_PREF = 4'hc;
  localparam logic [2:0] PM_NT = 3'h1;
  localparam logic [2:0] PM_NT_DMA = 3'h2;
  localparam logic [2:0] PM_USW_NT = 3'h3;
  localparam logic [2:0] PM_USW_NT_DMA = 3'h4;
  localparam int ST_BAR_LSB = 0;
  localparam int ST_HIT_BIT = 4;
  localparam int ST_UR_BIT = 5;
  localparam int ST_PRESENT_BIT = 8;
  localparam int ST_URCNT_LSB = 16;

  function automatic logic [5:0] fit_size(input logic [31:0] setup, input logic is64);
    logic [5:0] sz;
    sz = setup[SU_SIZE_LSB +: 6];
    if (sz < SIZE_MIN)
      sz = SIZE_MIN;
    if (!is64 && sz > SIZE_MAX32)
      sz = SIZE_MAX32;
    return sz;
  endfunction

  function automatic logic [63:0] size_mask(input logic [5:0] sz);
    return (64'h1 << sz) - 64'h1;
  endfunction

  function automatic logic [63:0] lim64(input logic [31:0] hi, input logic [31:0] lo);
    return {hi, lo[31:10], LIMIT_LOW_ONES};
  endfunction

  function automatic logic ep_present(input logic [2:0] mode);
    return (mode == PM_NT) || (mode == PM_NT_DMA) || (mode == PM_USW_NT)
      || (mode == PM_USW_NT_DMA);
  endfunction
endpackage

// *** rtl/ntw_win_if.sv ***
// Window descriptor and match result passed between decoder and matcher
interface ntw_win_if;
  logic active;
  logic [63:0] base;
  logic [63:0] mask;
  logic [63:0] limit;
  logic [63:0] addr;
  logic in_ap;
  logic in_eff;
  modport ctl (output active, base, mask, limit, addr, input in_ap, in_eff);
  modport match (input active, base, mask, limit, addr, output in_ap, in_eff);
endinterface

// *** rtl/ntw_window_match.sv ***
// Aperture and effective-aperture compare for one window
module ntw_window_match (
  ntw_win_if.match win // Window descriptor in, match result out
);
  // Full aperture: all address bits above the size agree with the base
  assign win.in_ap = win.active && (((win.addr ^ win.base) & ~win.mask) == 64'h0);
  // A limit under the base leaves nothing; above the aperture it never bites
  assign win.in_eff = win.in_ap && (win.addr <= win.limit);
endmodule

// *** rtl/ntw_bar_decoder.sv ***
// Base address window decoder for one cross-domain endpoint
module ntw_bar_decoder (
  input wire logic ref_clk, // System clock
  input wire logic sys_rst, // Synchronous reset, active high
  input wire logic clk_en, // Clock enable, freezes all state when low
  input wire logic [2:0] port_mode, // Operating mode of the hosting port
  input wire logic [7:0] reg_addr, // Register byte address
  input wire logic [31:0] reg_wdata, // Register write data
  input wire logic reg_wr, // Register write strobe
  input wire logic reg_rd, // Register read strobe
  output logic [31:0] reg_rdata, // Register read data, cycle after strobe
  input wire logic tlp_valid, // Received request present
  input wire logic [63:0] tlp_addr, // Request address
  input wire logic tlp_mem, // Request is memory space, low for I/O
  output logic dec_valid, // Decode result present
  output logic dec_hit, // Request claimed by a window
  output logic [2:0] dec_bar, // Claiming window index
  output logic dec_unsup, // Request completes as unsupported
  output logic dec_cfg_space, // Hit lands in mapped configuration space
  output logic dec_lookup // Claiming window uses lookup translation
);
  logic [31:0] bar_reg [ntw_pkg::NUM_BAR];
  logic [31:0] setup_reg [ntw_pkg::NUM_BAR];
  logic [31:0] limit_reg [ntw_pkg::NUM_BAR];
  logic [31:0] bar_rd [ntw_pkg::NUM_BAR];
  logic [5:0] ap;
  logic [5:0] eff;
  logic cfgmap0;
  logic ep_en;
  logic wr_bar;
  logic wr_setup;
  logic wr_limit;
  logic idx_ok;
  logic [2:0] idx;
  logic [31:0] next_rdata;
  logic found;
  logic [2:0] sel;
  logic any_ap;
  logic next_unsup;
  logic last_hit;
  logic last_ur;
  logic [2:0] last_bar;
  logic [15:0] ur_count;

  assign ep_en = ntw_pkg::ep_present(port_mode);

  // Register address decode
  assign idx = reg_addr[4:2];
  assign idx_ok = (reg_addr[1:0] == 2'h0) && (idx < 3'h6);
  assign wr_bar = reg_wr && idx_ok && (reg_addr[7:5] == ntw_pkg::OFS_BAR[7:5]);
  assign wr_setup = reg_wr && idx_ok && (reg_addr[7:5] == ntw_pkg::OFS_SETUP[7:5]);
  assign wr_limit = reg_wr && idx_ok && (reg_addr[7:5] == ntw_pkg::OFS_LIMIT[7:5]);

  // Window base registers
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < ntw_pkg::NUM_BAR; i++)
      begin
        bar_reg[i] <= ntw_pkg::BAR_RST;
      end
    end
    else if (clk_en && wr_bar)
    begin
      bar_reg[idx] <= reg_wdata;
    end
  end

  // Setup registers; lookup selection only kept for windows two and four
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < ntw_pkg::NUM_BAR; i++)
      begin
        setup_reg[i] <= ntw_pkg::SETUP_RST;
      end
    end
    else if (clk_en && wr_setup)
    begin
      if (idx == 3'h2 || idx == 3'h4)
      begin
        setup_reg[idx] <= reg_wdata & ntw_pkg::SU_RW_MASK;
      end
      else
      begin
        setup_reg[idx] <= reg_wdata & ntw_pkg::SU_RW_MASK & ~ntw_pkg::SU_LUT_MASK;
      end
    end
  end

  // Limit registers, reset to the top of the address space
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < ntw_pkg::NUM_BAR; i++)
      begin
        limit_reg[i] <= ntw_pkg::LIMIT_RST;
      end
    end
    else if (clk_en && wr_limit)
    begin
      // Kept raw: an odd register serving as upper limit bits must not have ones forced in
      limit_reg[idx] <= reg_wdata;
    end
  end

  // One even/odd pair of windows per iteration
  for (genvar p = 0; p < 3; p++)
  begin : g_pair
    localparam int E = 2 * p;
    localparam int O = 2 * p + 1;
    ntw_win_if win_e ();
    ntw_win_if win_o ();
    logic p64;
    logic cfgm;
    logic [5:0] size_e;
    logic [5:0] size_o;

    assign p64 = setup_reg[E][ntw_pkg::SU_MODE64_BIT];
    if (p == 0)
    begin : g_cfg
      assign cfgm = setup_reg[E][ntw_pkg::SU_CFGMAP_BIT];
    end
    else
    begin : g_nocfg
      assign cfgm = 1'b0;
    end
    assign size_e = cfgm ? ntw_pkg::CFG_SIZE : ntw_pkg::fit_size(setup_reg[E], p64);
    assign size_o = ntw_pkg::fit_size(setup_reg[O], 1'b0);

    // Even window, 32-bit or lower half of a 64-bit pair
    assign win_e.active = ep_en && setup_reg[E][ntw_pkg::SU_EN_BIT];
    assign win_e.mask = ntw_pkg::size_mask(size_e);
    assign win_e.base = {p64 ? bar_reg[O] : 32'h0, bar_reg[E]} & ~win_e.mask;
    assign win_e.limit = cfgm ? ntw_pkg::LIMIT_MAX64
      : ntw_pkg::lim64(p64 ? limit_reg[O] : 32'h0, limit_reg[E]);
    assign win_e.addr = tlp_addr;

    // Odd window, silenced when it serves as the upper half
    assign win_o.active = ep_en && setup_reg[O][ntw_pkg::SU_EN_BIT] && !p64;
    assign win_o.mask = ntw_pkg::size_mask(size_o);
    assign win_o.base = {32'h0, bar_reg[O]} & ~win_o.mask;
    assign win_o.limit = ntw_pkg::lim64(32'h0, limit_reg[O]);
    assign win_o.addr = tlp_addr;

    ntw_window_match u_match_e (
      .win (win_e)
    );
    ntw_window_match u_match_o (
      .win (win_o)
    );

    assign ap[E] = win_e.in_ap;
    assign eff[E] = win_e.in_eff;
    assign ap[O] = win_o.in_ap;
    assign eff[O] = win_o.in_eff;

    // Size bits read back as zero; low nibble flags memory type, except on an odd register serving as upper base bits
    assign bar_rd[E] = (bar_reg[E] & ~win_e.mask[31:0])
      | 32'(p64 ? ntw_pkg::BAR_TYPE64_PREF : ntw_pkg::BAR_TYPE32);
    assign bar_rd[O] = p64 ? (bar_reg[O] & ~win_e.mask[63:32])
      : ((bar_reg[O] & ~win_o.mask[31:0]) | 32'(ntw_pkg::BAR_TYPE32));
  end

  assign cfgmap0 = g_pair[0].cfgm;

  // Lowest claiming window wins; overlaps are software's fault
  always_comb
  begin
    found = 1'b0;
    sel = 3'h0;
    for (int i = ntw_pkg::NUM_BAR - 1; i >= 0; i--)
    begin
      if (eff[i])
      begin
        found = 1'b1;
        sel = 3'(i);
      end
    end
  end

  assign any_ap = |ap;
  assign next_unsup = tlp_mem && any_ap && !found;

  // Registered decode result
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      dec_valid <= 1'b0;
      dec_hit <= 1'b0;
      dec_bar <= 3'h0;
      dec_unsup <= 1'b0;
      dec_cfg_space <= 1'b0;
      dec_lookup <= 1'b0;
    end
    else if (clk_en)
    begin
      dec_valid <= tlp_valid;
      dec_hit <= tlp_valid && tlp_mem && found;
      dec_bar <= sel;
      dec_unsup <= tlp_valid && next_unsup;
      dec_cfg_space <= tlp_valid && tlp_mem && found && (sel == 3'h0) && cfgmap0;
      dec_lookup <= tlp_valid && tlp_mem && found
        && setup_reg[sel][ntw_pkg::SU_LUT_BIT];
    end
  end

  // Status of the most recent decode and a count of unsupported requests
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      last_hit <= 1'b0;
      last_ur <= 1'b0;
      last_bar <= 3'h0;
      ur_count <= 16'h0000;
    end
    else if (clk_en && tlp_valid)
    begin
      last_hit <= tlp_mem && found;
      last_ur <= next_unsup;
      last_bar <= sel;
      if (next_unsup)
      begin
        ur_count <= ur_count + 16'h0001;
      end
    end
  end

  // Read multiplexer; unmapped addresses read zero
  always_comb
  begin
    next_rdata = 32'h0;
    if (reg_addr[7:5] == ntw_pkg::OFS_STATUS[7:5] && reg_addr[4:0] == 5'h00)
    begin
      next_rdata[ntw_pkg::ST_BAR_LSB +: 3] = last_bar;
      next_rdata[ntw_pkg::ST_HIT_BIT] = last_hit;
      next_rdata[ntw_pkg::ST_UR_BIT] = last_ur;
      next_rdata[ntw_pkg::ST_PRESENT_BIT] = ep_en;
      next_rdata[ntw_pkg::ST_URCNT_LSB +: 16] = ur_count;
    end
    else if (idx_ok)
    begin
      case (reg_addr[7:5])
        ntw_pkg::OFS_BAR[7:5]: next_rdata = bar_rd[idx];
        ntw_pkg::OFS_SETUP[7:5]: next_rdata = setup_reg[idx];
        ntw_pkg::OFS_LIMIT[7:5]: next_rdata = {limit_reg[idx][31:10], ntw_pkg::LIMIT_LOW_ONES};
        default: next_rdata = 32'h0;
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      reg_rdata <= 32'h0;
    end
    else if (clk_en)
    begin
      reg_rdata <= reg_rd ? next_rdata : 32'h0;
    end
  end
endmodule

// *** tb/ntw_bar_checker.sv ***
// Port-level assertions for the window decoder
module ntw_bar_checker (
  input wire logic ref_clk, // Clock
  input wire logic sys_rst, // Reset
  input wire logic clk_en, // Enable
  input wire logic [2:0] port_mode, // Port mode
  input wire logic [7:0] reg_addr, // Address
  input wire logic reg_rd, // Read strobe
  input wire logic [31:0] reg_rdata, // Read data
  input wire logic tlp_valid, // Request
  input wire logic tlp_mem, // Memory request
  input wire logic dec_valid, // Result
  input wire logic dec_hit, // Hit
  input wire logic [2:0] dec_bar, // Window
  input wire logic dec_unsup, // Unsupported
  input wire logic dec_cfg_space, // Config hit
  input wire logic dec_lookup // Lookup
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  AST_VALID_LAT: assert property (clk_en && tlp_valid |=> dec_valid)
    else $error("decode result missing");
  AST_VALID_CAUSE: assert property (dec_valid |-> $past(tlp_valid))
    else $error("decode result without request");
  AST_IDLE_QUIET: assert property (!dec_valid |-> !(dec_hit || dec_unsup || dec_lookup))
    else $error("decode flags without result");
  AST_IO_REFUSED: assert property (clk_en && tlp_valid && !tlp_mem |=> !dec_hit && !dec_unsup)
    else $error("io request decoded");
  AST_ABSENT: assert property (clk_en && tlp_valid && !(port_mode inside {[3'h1:3'h4]})
    |=> !dec_hit)
    else $error("hit without endpoint");
  AST_HIT_XOR_UR: assert property (dec_hit |-> !dec_unsup)
    else $error("hit and unsupported together");
  AST_BAR_RANGE: assert property (dec_hit |-> dec_bar <= 3'h5)
    else $error("window index out of range");
  AST_CFG_BAR0: assert property (dec_cfg_space |-> dec_hit && dec_bar == 3'h0)
    else $error("config hit not on window zero");
  AST_LOOKUP_BAR: assert property (dec_lookup |-> dec_hit && dec_bar inside {3'h2, 3'h4})
    else $error("lookup on wrong window");
  AST_LIMIT_ONES: assert property (clk_en && reg_rd && reg_addr inside {[8'h40:8'h54]}
    && reg_addr[1:0] == 2'h0 |=> reg_rdata[9:0] == 10'h3ff)
    else $error("limit low bits not ones");
  AST_RD_WINDOW: assert property (reg_rdata != 32'h0 |-> $past(reg_rd))
    else $error("read data outside read cycle");
endmodule
bind ntw_bar_decoder ntw_bar_checker i_ntw_bar_checker (.ref_clk, .sys_rst, .clk_en,
  .port_mode, .reg_addr, .reg_rd, .reg_rdata, .tlp_valid, .tlp_mem, .dec_valid, .dec_hit,
  .dec_bar, .dec_unsup, .dec_cfg_space, .dec_lookup);

// *** tb/ntw_host_model.sv ***
// Requester model issuing memory and io requests
module ntw_host_model (
  input wire logic ref_clk, // Clock
  output logic tlp_valid, // Request present
  output logic [63:0] tlp_addr, // Request address
  output logic tlp_mem // Memory request
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    tlp_valid = 1'b0;
    tlp_addr = '1;
    tlp_mem = 1'b0;
  end
  // One doubleword per request; callers may issue back to back
  task automatic issue(input logic [63:0] a, input logic m);
    @(posedge ref_clk);
    tlp_valid <= 1'b1;
    tlp_addr <= a;
    tlp_mem <= m;
  endtask
  // Released address lines do not keep the last value
  task automatic idle(input int n);
    @(posedge ref_clk);
    tlp_valid <= 1'b0;
    tlp_addr <= ~tlp_addr;
    repeat (n) @(posedge ref_clk);
  endtask
endmodule

// *** tb/nt_bar_window_decoder_tb_top.sv ***
// Self-checking bench for the window decoder
module nt_bar_window_decoder_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [2:0] port_mode = 3'h1;
  logic [7:0] reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic clk_en = 1'b1;
  int urs = 0;
  logic [31:0] reg_rdata;
  logic tlp_valid, tlp_mem, dec_valid, dec_hit, dec_unsup, dec_cfg_space, dec_lookup;
  logic [63:0] tlp_addr;
  logic [2:0] dec_bar;
  int failures = 0;
  int checked = 0;
  int seed = 44539;
  logic [31:0] bs [6];
  logic [31:0] su [6];
  logic [31:0] lm [6];
  logic [6:0] exp_q [$];
  always #5 ref_clk = ~ref_clk;
  ntw_bar_decoder i_ntw_bar_decoder (.ref_clk, .sys_rst, .clk_en, .port_mode,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .tlp_valid, .tlp_addr, .tlp_mem,
    .dec_valid, .dec_hit, .dec_bar, .dec_unsup, .dec_cfg_space, .dec_lookup);
  ntw_host_model i_ntw_host_model (.ref_clk, .tlp_valid, .tlp_addr, .tlp_mem);
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    checked++;
    if (g !== e)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] k);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    chk("reg_rdata", e & k, reg_rdata & k);
  endtask
  // Expected {hit, window, unsupported, config, lookup}
  function automatic logic [6:0] model(input logic [63:0] a, input logic m);
    logic [63:0] k, b, l;
    logic [6:0] r;
    logic u, p, c;
    r = 7'h0;
    u = 1'b0;
    if (!m || port_mode < 3'h1 || port_mode > 3'h4)
      return r;
    for (int i = 0; i < 6; i++)
    begin
      p = i % 2 == 0 && su[i][1];
      c = i == 0 && su[0][2];
      if (su[i][0] && !(i % 2 == 1 && su[i-1][1]))
      begin
        k = (64'h1 << (c ? 12 : su[i][9:4])) - 64'h1;
        b = {p ? bs[i+1] : 32'h0, bs[i]} & ~k;
        l = c ? '1 : {p ? lm[i+1] : 32'h0, lm[i][31:10], 10'h3ff};
        if ((a & ~k) == b && !r[6])
          if (a <= l)
            r = {1'b1, 3'(i), 1'b0, c, (i == 2 || i == 4) && su[i][12]};
          else
            u = 1'b1;
      end
    end
    r[2] = u && !r[6];
    return r;
  endfunction
  always @(negedge ref_clk)
    if (dec_valid === 1'b1)
      chk("decode", exp_q.size() > 0 ? exp_q.pop_front() : 7'h7f,
        {dec_hit, dec_hit ? dec_bar : 3'h0, dec_unsup, dec_cfg_space, dec_lookup});
  task automatic end_sim;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    #300000;
    failures++;
    end_sim();
  end
  initial
  begin
    logic [63:0] a;
    logic m;
    int sz, w;
    logic [6:0] e;
    logic [31:0] sv;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 6; i++)
    begin
      rdc(ntw_pkg::OFS_LIMIT + 8'(4 * i), 32'hffff_ffff, '1);
      rdc(ntw_pkg::OFS_SETUP + 8'(4 * i), ntw_pkg::SETUP_RST, '1);
    end
    wr(8'h80, 32'h5a5a_5a5a);
    rdc(8'h80, 32'h0, '1);
    for (int r = 0; r < 24; r++)
    begin
      @(posedge ref_clk);
      port_mode <= 3'($random(seed));
      for (int i = 0; i < 6; i++)
      begin
        sz = 10 + $unsigned($random(seed)) % 14;
        su[i] = (32'($random(seed)) & 32'h1007) | 32'(sz << 4);
        m = i % 2 == 1 && su[i-1][1];
        bs[i] = m ? 32'(i) : 32'(i) << 24;
        lm[i] = m ? 32'(i) - 32'($random(seed) & 1)
          : bs[i] + 32'($random(seed) & ((2 << sz) - 1)) - 32'(1 << (sz - 1));
        wr(ntw_pkg::OFS_BAR + 8'(4 * i), m ? bs[i] : bs[i] | 32'h3ff);
        wr(ntw_pkg::OFS_SETUP + 8'(4 * i), su[i]);
        wr(ntw_pkg::OFS_LIMIT + 8'(4 * i), lm[i]);
        rdc(ntw_pkg::OFS_LIMIT + 8'(4 * i), {lm[i][31:10], 10'h3ff}, '1);
        if (m)
          rdc(ntw_pkg::OFS_SETUP + 8'(4 * i), su[i], 32'h3f1);
        else
          rdc(ntw_pkg::OFS_BAR + 8'(4 * i), bs[i] | (su[i][1] && i % 2 == 0 ? 32'hc : 0), '1);
      end
      repeat (40)
      begin
        w = $unsigned($random(seed)) % 6;
        if (w % 2 == 1 && su[w-1][1])
          w = w - 1;
        sz = w == 0 && su[0][2] ? 12 : su[w][9:4];
        a = {w % 2 == 0 && su[w][1] ? bs[w+1] : 32'h0, bs[w]}
          + 64'($random(seed) & ((2 << sz) - 1)) - 64'(1 << (sz - 1));
        m = ($random(seed) & 7) != 0;
        e = model(a, m);
        exp_q.push_back(e);
        urs += e[2];
        i_ntw_host_model.issue(a, m);
        if (($random(seed) & 3) == 0)
          i_ntw_host_model.idle($unsigned($random(seed)) % 3);
      end
      i_ntw_host_model.idle(2);
      // Status shows the last request and the running count of unsupported requests
      sv = {16'(urs), 7'h0, 1'(port_mode inside {[3'h1:3'h4]}), 2'h0, e[2], e[6], 1'b0, e[5:3]};
      rdc(ntw_pkg::OFS_STATUS, sv, e[6] ? '1 : 32'hffff_fff8);
    end
    // A write while the clock enable is low must not land
    @(posedge ref_clk);
    clk_en <= 1'b0;
    wr(ntw_pkg::OFS_LIMIT, 32'h0);
    clk_en <= 1'b1;
    rdc(ntw_pkg::OFS_LIMIT, {lm[0][31:10], 10'h3ff}, '1);
    // Mid-run reset brings limits and status back to their reset values
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    @(posedge ref_clk);
    sys_rst <= 1'b0;
    rdc(ntw_pkg::OFS_LIMIT + 8'h04, 32'hffff_ffff, '1);
    rdc(ntw_pkg::OFS_STATUS, {23'h0, 1'(port_mode inside {[3'h1:3'h4]}), 8'h0}, '1);
    chk("pending", 64'h0, 64'(exp_q.size()));
    end_sim();
  end
endmodule
